// >>> src/ptio_top.v
/*
  Pulse train input measurement and pulse train output generator with an
  APB register slave.
  Assumes one 10 MHz clock; pulse_in_pin and encoder_pulse are asynchronous,
  the source percentages come from logic on pclk.
*/
// The implementer's own choices: the placing of the registers and register access over APB.
// Behaviour
// - Mode 0 frequency, mode 1 PWM duty.
// - Frequency ratio is input frequency over scale.
// - PWM ratio is high time over period.
// - PWM period beyond 12.5 percent means inactive.
// - Input scale sets the 100 percent rate.
// - Target is percentage times gain plus bias.
// - Settable smoothing filter on measured input.
// - Monitor reports input percentage of scale.
// - Pulse reference when source 4 and frequency mode.
// - PWM mode without pulse PID feedback errors.
// - Frequency mode with PID enabled errors.
// - Output source selects codes 1 to 7.
// - Output scale is rate at 100 percent.
// - Encoder pass-through is one to one.
// - Output frequency with zero scale passes directly.
// - Optocoupler polarity bit inverts the output.
`default_nettype none
`include "ptio_defs.vh"

module ptio_top #(
    parameter [23:0] FILT_STEP_CYC = `PTIO_CLK_HZ / `PTIO_FILT_UNIT_PER_S / (1 << `PTIO_FILT_SHIFT)
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PTIO_AW-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_q,
    output reg pready_q,
    output reg pslverr_q,
    input wire pulse_in_pin,
    input wire encoder_pulse,
    input wire [15:0] freq_cmd_pct,
    input wire [15:0] out_freq_pct,
    input wire [15:0] soft_start_stage_pct,
    input wire [15:0] motor_speed_pct,
    input wire [15:0] pid_fb_pct,
    input wire [15:0] pid_in_pct,
    input wire [15:0] out_freq_centihz,
    input wire opto_func,
    output reg pulse_out_pin,
    output reg optocoupler_output,
    output reg pulse_setting_error,
    output reg pulse_ref_active_q,
    output reg [23:0] pulse_freq_ref_q
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg in_mode_q;
    reg [2:0] ref_sel_q;
    reg [3:0] pid_fb_q;
    reg pid_en_q;
    reg [2:0] out_sel_q;
    reg opto_pol_q;
    reg [15:0] in_scale_q;
    reg [15:0] gain_q;
    reg [15:0] bias_q;
    reg [7:0] filt_q;
    reg [15:0] out_scale_q;

    wire acc_en = psel & penable & pready_q;
    wire wr_en = acc_en & pwrite;
    wire [31:0] ctrl_rd = {11'h000, opto_pol_q, 1'b0, out_sel_q, 3'h0, pid_en_q, pid_fb_q,
                           1'b0, ref_sel_q, 3'h0, in_mode_q};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_mode_q <= `PTIO_MODE_FREQ;
            ref_sel_q <= 3'h0;
            pid_fb_q <= 4'h0;
            pid_en_q <= 1'b0;
            out_sel_q <= `PTIO_RST_OSEL;
            opto_pol_q <= 1'b0;
            in_scale_q <= `PTIO_RST_IN_SCALE;
            gain_q <= `PTIO_RST_GAIN;
            bias_q <= `PTIO_RST_BIAS;
            filt_q <= `PTIO_RST_FILT;
            out_scale_q <= `PTIO_RST_OUT_SCALE;
        end else if (wr_en) begin
            case (paddr)
                `PTIO_ADDR_CTRL: begin
                    in_mode_q <= pwdata[`PTIO_CTRL_MODE];
                    ref_sel_q <= pwdata[`PTIO_CTRL_REF_HI:`PTIO_CTRL_REF_LO];
                    pid_fb_q <= pwdata[`PTIO_CTRL_PIDFB_HI:`PTIO_CTRL_PIDFB_LO];
                    pid_en_q <= pwdata[`PTIO_CTRL_PIDEN];
                    out_sel_q <= pwdata[`PTIO_CTRL_OSEL_HI:`PTIO_CTRL_OSEL_LO];
                    opto_pol_q <= pwdata[`PTIO_CTRL_POL];
                end
                `PTIO_ADDR_IN_SCALE: in_scale_q <= pwdata[15:0];
                `PTIO_ADDR_GAIN: gain_q <= pwdata[15:0];
                `PTIO_ADDR_BIAS: bias_q <= pwdata[15:0];
                `PTIO_ADDR_FILT: filt_q <= pwdata[7:0];
                `PTIO_ADDR_OUT_SCALE: out_scale_q <= pwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Input synchronisers and edge counting
    // ----------------------------------------
    reg [2:0] pin_sync_q;
    reg [1:0] enc_sync_q;
    reg [23:0] cnt_q;
    reg [23:0] hi_cnt_q;
    reg [23:0] period_q;
    reg [23:0] high_q;
    reg seen_q;
    reg start_q;
    wire rise = pin_sync_q[1] & ~pin_sync_q[2];
    wire fall = ~pin_sync_q[1] & pin_sync_q[2];
    wire stale = &cnt_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync_q <= 3'h0;
            enc_sync_q <= 2'h0;
            cnt_q <= 24'h000000;
            hi_cnt_q <= 24'h000000;
            period_q <= 24'h000000;
            high_q <= 24'h000000;
            seen_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], pulse_in_pin};
            enc_sync_q <= {enc_sync_q[0], encoder_pulse};
            start_q <= rise & seen_q & ~stale;
            if (rise) begin
                cnt_q <= 24'h000001;
                period_q <= cnt_q;
                high_q <= hi_cnt_q;
                seen_q <= 1'b1;
            end else if (!stale) begin
                cnt_q <= cnt_q + 24'h000001;
            end
            if (fall) begin
                hi_cnt_q <= cnt_q;
            end
        end
    end

    // ----------------------------------------
    // Ratio computation
    // ----------------------------------------
    // Frequency ratio is clk*full/(period*scale), so no division by period alone is needed.
    wire [39:0] prod_ps = {16'h0000, period_q} * {24'h000000, in_scale_q};
    wire [39:0] clk_full = `PTIO_CLK_HZ * 40'd10000;
    wire [39:0] clk_w = 40'd0 + `PTIO_CLK_HZ;
    wire [39:0] prod_ps8 = prod_ps << `PTIO_TOL_SH;
    wire tol_ok = (prod_ps8 >= clk_w * `PTIO_TOL_LO) && (prod_ps8 <= clk_w * `PTIO_TOL_HI);
    wire [39:0] high_full = {16'h0000, high_q} * 40'd10000;
    wire [39:0] div_num = (in_mode_q == `PTIO_MODE_PWM) ? high_full : clk_full;
    wire [39:0] div_den = (in_mode_q == `PTIO_MODE_PWM) ? {16'h0000, period_q} : prod_ps;
    wire div_done;
    wire [39:0] div_quo;
    wire den_ok = |div_den;
    reg [15:0] raw_q;
    reg active_q;

    ptio_divu u_div (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_q & den_ok),
        .num(div_num),
        .den(div_den),
        .done_q(div_done),
        .quo_q(div_quo)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_q <= 16'h0000;
            active_q <= 1'b0;
        end else if (stale) begin
            raw_q <= 16'h0000;
            active_q <= 1'b0;
        end else if (div_done) begin
            if (in_mode_q == `PTIO_MODE_PWM && !tol_ok) begin
                raw_q <= 16'h0000;
                active_q <= 1'b0;
            end else begin
                raw_q <= (|div_quo[39:16]) ? 16'hFFFF : div_quo[15:0];
                active_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Smoothing filter
    // ----------------------------------------
    // Moving 1/16 of the error every filt*10ms/16 gives a time constant near filt*10ms.
    reg [19:0] filt_acc_q;
    reg [23:0] tick_cnt_q;
    wire [31:0] tick_lim_w = {24'h000000, filt_q} * {8'h00, FILT_STEP_CYC};
    wire [23:0] tick_lim = tick_lim_w[23:0];
    wire [20:0] err = {1'b0, raw_q, 4'h0} - {1'b0, filt_acc_q};
    wire [20:0] err_sh = {{`PTIO_FILT_SHIFT{err[20]}}, err[20:`PTIO_FILT_SHIFT]};
    wire [20:0] acc_nx = {1'b0, filt_acc_q} + err_sh;
    wire [15:0] mon_pct = filt_acc_q[19:4];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_acc_q <= 20'h00000;
            tick_cnt_q <= 24'h000000;
        end else if (filt_q == `PTIO_RST_FILT) begin
            filt_acc_q <= {raw_q, 4'h0};
            tick_cnt_q <= 24'h000000;
        end else if (tick_cnt_q + 24'h000001 >= tick_lim) begin
            tick_cnt_q <= 24'h000000;
            filt_acc_q <= acc_nx[19:0];
        end else begin
            tick_cnt_q <= tick_cnt_q + 24'h000001;
        end
    end

    // ----------------------------------------
    // Gain, bias and status
    // ----------------------------------------
    // The division by 1000 uses a fixed reciprocal that reads slightly low; at full-scale mon_pct and gain_q the error reaches about 56 counts.
    wire [47:0] gprod = {16'h0000, mon_pct, 16'h0000} >> 16;
    wire [47:0] gmul = gprod[31:0] * gain_q * `PTIO_GAIN_RECIP;
    wire [47:0] gscl = gmul >> `PTIO_GAIN_SH;
    wire [23:0] bias_x = {{8{bias_q[15]}}, bias_q} * {8'h00, `PTIO_BIAS_MUL};
    wire [23:0] target = gscl[23:0] + bias_x;
    reg [23:0] target_q;
    wire err_pwm = (in_mode_q == `PTIO_MODE_PWM) && (pid_fb_q != `PTIO_PIDFB_PULSE);
    wire err_freq = (in_mode_q == `PTIO_MODE_FREQ) && pid_en_q;
    wire ref_on = (ref_sel_q == `PTIO_REF_PULSE) && (in_mode_q == `PTIO_MODE_FREQ);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_q <= 24'h000000;
            pulse_setting_error <= 1'b0;
            pulse_ref_active_q <= 1'b0;
            pulse_freq_ref_q <= 24'h000000;
            optocoupler_output <= 1'b0;
        end else begin
            target_q <= target;
            pulse_setting_error <= err_pwm | err_freq;
            pulse_ref_active_q <= ref_on;
            pulse_freq_ref_q <= ref_on ? target_q : 24'h000000;
            optocoupler_output <= opto_func ^ opto_pol_q;
        end
    end

    // ----------------------------------------
    // Pulse output
    // ----------------------------------------
    reg [15:0] src_pct;
    always @* begin
        case (out_sel_q)
            `PTIO_OSEL_FREQ_CMD: src_pct = freq_cmd_pct;
            `PTIO_OSEL_OUT_FREQ: src_pct = out_freq_pct;
            `PTIO_OSEL_SOFT: src_pct = soft_start_stage_pct;
            `PTIO_OSEL_SPEED: src_pct = motor_speed_pct;
            `PTIO_OSEL_PID_FB: src_pct = pid_fb_pct;
            `PTIO_OSEL_PID_IN: src_pct = pid_in_pct;
            default: src_pct = 16'h0000;
        endcase
    end

    wire [31:0] ps_prod = {16'h0000, src_pct} * {16'h0000, out_scale_q};
    wire [63:0] step_s = {32'h00000000, ps_prod} * {32'h00000000, `PTIO_NCO_K};
    wire [63:0] step_h = {48'h000000000000, out_freq_centihz} * {32'h00000000, `PTIO_NCO_KHZ};
    wire [63:0] step_s_sh = step_s >> `PTIO_NCO_SH;
    wire [63:0] step_h_sh = step_h >> `PTIO_NCO_SHHZ;
    wire direct = (out_sel_q == `PTIO_OSEL_OUT_FREQ) && (out_scale_q == 16'h0000);
    reg [31:0] step_q;
    wire nco_pulse;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_q <= 32'h00000000;
            pulse_out_pin <= 1'b0;
        end else begin
            step_q <= direct ? step_h_sh[31:0] : step_s_sh[31:0];
            pulse_out_pin <= (out_sel_q == `PTIO_OSEL_ENC) ? enc_sync_q[1] : nco_pulse;
        end
    end

    ptio_nco u_nco (
        .pclk(pclk),
        .presetn(presetn),
        .step(step_q),
        .pulse_q(nco_pulse)
    );

    // ----------------------------------------
    // APB read path
    // ----------------------------------------
    reg [31:0] rd_data;
    reg rd_ok;
    always @* begin
        rd_ok = 1'b1;
        case (paddr)
            `PTIO_ADDR_CTRL: rd_data = ctrl_rd;
            `PTIO_ADDR_IN_SCALE: rd_data = {16'h0000, in_scale_q};
            `PTIO_ADDR_GAIN: rd_data = {16'h0000, gain_q};
            `PTIO_ADDR_BIAS: rd_data = {16'h0000, bias_q};
            `PTIO_ADDR_FILT: rd_data = {24'h000000, filt_q};
            `PTIO_ADDR_OUT_SCALE: rd_data = {16'h0000, out_scale_q};
            `PTIO_ADDR_MON: rd_data = {16'h0000, mon_pct};
            `PTIO_ADDR_TARGET: rd_data = {{8{target_q[23]}}, target_q};
            `PTIO_ADDR_STATUS: rd_data = {29'h00000000, pulse_ref_active_q, pulse_setting_error, active_q};
            default: begin
                rd_data = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // Answer is prepared in the setup cycle so that the access phase never waits.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_data;
            pready_q <= 1'b1;
            pslverr_q <= ~rd_ok;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end
endmodule // ptio_top

`default_nettype wire

// >>> inc/ptio_defs.vh
/*
  Constants of the pulse train input/output block: register map, field
  positions, reset values and timing figures.
  Assumes a 10 MHz pclk and 32-bit APB data.
*/
`ifndef PTIO_DEFS_VH
`define PTIO_DEFS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define PTIO_CLK_HZ 10000000
`define PTIO_FILT_UNIT_PER_S 100
`define PTIO_FILT_SHIFT 4
`define PTIO_PCT_FULL 10000

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PTIO_AW 12
`define PTIO_ADDR_CTRL 12'h000
`define PTIO_ADDR_IN_SCALE 12'h004
`define PTIO_ADDR_GAIN 12'h008
`define PTIO_ADDR_BIAS 12'h00C
`define PTIO_ADDR_FILT 12'h010
`define PTIO_ADDR_OUT_SCALE 12'h014
`define PTIO_ADDR_MON 12'h020
`define PTIO_ADDR_TARGET 12'h024
`define PTIO_ADDR_STATUS 12'h028

// ----------------------------------------
// Control fields
// ----------------------------------------
`define PTIO_CTRL_MODE 0
`define PTIO_CTRL_REF_LO 4
`define PTIO_CTRL_REF_HI 6
`define PTIO_CTRL_PIDFB_LO 8
`define PTIO_CTRL_PIDFB_HI 11
`define PTIO_CTRL_PIDEN 12
`define PTIO_CTRL_OSEL_LO 16
`define PTIO_CTRL_OSEL_HI 18
`define PTIO_CTRL_POL 20

// ----------------------------------------
// Codes
// ----------------------------------------
`define PTIO_MODE_FREQ 1'b0
`define PTIO_MODE_PWM 1'b1
`define PTIO_REF_PULSE 3'h4
`define PTIO_PIDFB_PULSE 4'h3
`define PTIO_OSEL_FREQ_CMD 3'h1
`define PTIO_OSEL_OUT_FREQ 3'h2
`define PTIO_OSEL_SOFT 3'h3
`define PTIO_OSEL_SPEED 3'h4
`define PTIO_OSEL_PID_FB 3'h5
`define PTIO_OSEL_PID_IN 3'h6
`define PTIO_OSEL_ENC 3'h7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PTIO_RST_IN_SCALE 16'h2710
`define PTIO_RST_GAIN 16'h03E8
`define PTIO_RST_BIAS 16'h0000
`define PTIO_RST_FILT 8'h00
`define PTIO_RST_OUT_SCALE 16'h2710
`define PTIO_RST_OSEL 3'h2

// ----------------------------------------
// Arithmetic constants
// ----------------------------------------
`define PTIO_DIV_W 40
`define PTIO_TOL_LO 40'd7
`define PTIO_TOL_HI 40'd9
`define PTIO_TOL_SH 3
`define PTIO_GAIN_RECIP 16'd33554
`define PTIO_GAIN_SH 25
`define PTIO_BIAS_MUL 16'd10
`define PTIO_NCO_K 32'd2951479052
`define PTIO_NCO_SH 36
`define PTIO_NCO_KHZ 32'd1152921505
`define PTIO_NCO_SHHZ 28

`endif

// >>> src/ptio_divu.v
/*
  Unsigned restoring divider, one quotient bit per cycle.
  Assumes start is a single-cycle pulse and den is nonzero.
*/
`default_nettype none
`include "ptio_defs.vh"

module ptio_divu (
    input wire pclk,
    input wire presetn,
    input wire start,
    input wire [`PTIO_DIV_W-1:0] num,
    input wire [`PTIO_DIV_W-1:0] den,
    output reg done_q,
    output reg [`PTIO_DIV_W-1:0] quo_q
);
    reg [`PTIO_DIV_W-1:0] rem_q;
    reg [`PTIO_DIV_W-1:0] den_q;
    reg [5:0] bit_q;
    reg busy_q;
    wire [`PTIO_DIV_W:0] trial = {rem_q, quo_q[`PTIO_DIV_W-1]};
    wire fits = trial >= {1'b0, den_q};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rem_q <= {`PTIO_DIV_W{1'b0}};
            den_q <= {`PTIO_DIV_W{1'b0}};
            quo_q <= {`PTIO_DIV_W{1'b0}};
            bit_q <= 6'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                rem_q <= {`PTIO_DIV_W{1'b0}};
                quo_q <= num;
                den_q <= den;
                bit_q <= 6'h00;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                rem_q <= fits ? trial[`PTIO_DIV_W-1:0] - den_q : trial[`PTIO_DIV_W-1:0];
                quo_q <= {quo_q[`PTIO_DIV_W-2:0], fits};
                bit_q <= bit_q + 6'h01;
                if (bit_q == 6'h27) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end
endmodule // ptio_divu

`default_nettype wire

// >>> src/ptio_nco.v
/*
  Phase accumulator pulse generator; the accumulator top bit is the pulse.
  Assumes step is stable between updates on the same clock.
*/
`default_nettype none

module ptio_nco (
    input wire pclk,
    input wire presetn,
    input wire [31:0] step,
    output reg pulse_q
);
    reg [31:0] acc_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 32'h00000000;
            pulse_q <= 1'b0;
        end else begin
            acc_q <= acc_q + step;
            pulse_q <= acc_q[31];
        end
    end
endmodule // ptio_nco

`default_nettype wire

// >>> dv/ptio_pulse_ext.sv
/* Partner model: external pulse source on the input pin, follower on the output pin.
   Assumes the bench supplies pclk and sets period_cyc and high_cyc. */
`default_nettype none
module ptio_pulse_ext (
    input wire logic pclk,
    input wire logic pulse_out_pin,
    output logic pulse_in_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int period_cyc = 1000;
    int high_cyc = 400;
    int rise_cnt = 0, cyc = 0, last_rise = 0, gap = 0, cur_p, cur_h;
    logic prev = 1'b0;
    // ------
    // Source
    // ------
    // New settings apply from a rise on.
    initial begin
        pulse_in_pin = 1'b0;
        forever begin
            @(posedge pclk);
            cur_p = period_cyc;
            cur_h = high_cyc;
            pulse_in_pin <= 1'b1;
            repeat (cur_h) @(posedge pclk);
            pulse_in_pin <= 1'b0;
            repeat (cur_p - cur_h - 1) @(posedge pclk);
        end
    end
    // Follower: counts rises on the output pin and the gap between the last two.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        prev <= pulse_out_pin;
        if (pulse_out_pin && !prev) begin
            rise_cnt <= rise_cnt + 1;
            last_rise <= cyc;
            gap <= cyc - last_rise;
        end
    end
endmodule // ptio_pulse_ext
`default_nettype wire

// >>> dv/ptio_top_checker.sv
/* Assertions on the ports of ptio_top.
   Assumes it is bound to ptio_top and sees only its ports. */
`default_nettype none
`include "ptio_defs.vh"
module ptio_top_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PTIO_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready_q,
    input wire logic pslverr_q,
    input wire logic encoder_pulse,
    input wire logic opto_func,
    input wire logic pulse_out_pin,
    input wire logic optocoupler_output,
    input wire logic pulse_setting_error,
    input wire logic pulse_ref_active_q,
    input wire logic [23:0] pulse_freq_ref_q
);
    logic [31:0] ctrl_q;
    logic [2:0] age_q;
    logic ok;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------
    // Shadow
    // ------
    // Checks wait a few cycles after a control write, since outputs are registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 32'h00020000;
            age_q <= 3'h0;
        end else if (psel && penable && pwrite && pready_q && paddr == `PTIO_ADDR_CTRL) begin
            ctrl_q <= pwdata;
            age_q <= 3'h0;
        end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
        end
    end
    assign ok = age_q > 3'h3;
    // ------
    // Properties
    // ------
    a_ready_next: assert property (psel && !penable |=> pready_q ##1 !pready_q)
        else $error("ready not single");
    a_ready_cause: assert property (pready_q |-> $past(psel && !penable))
        else $error("ready without setup");
    a_err_ready: assert property (pslverr_q |-> pready_q)
        else $error("error without ready");
    a_set_err: assert property (ok |-> pulse_setting_error ==
        ((ctrl_q[0] && ctrl_q[11:8] != 4'h3) || (!ctrl_q[0] && ctrl_q[12]))) else $error("setting error");
    a_ref_sel: assert property (ok |-> pulse_ref_active_q == (ctrl_q[6:4] == 3'h4 && !ctrl_q[0]))
        else $error("reference select");
    a_ref_zero: assert property (!pulse_ref_active_q |-> pulse_freq_ref_q == 24'h000000)
        else $error("reference not zero");
    a_opto_pol: assert property (ok |-> optocoupler_output == ($past(opto_func) ^ ctrl_q[20]))
        else $error("opto polarity");
    a_enc_pass: assert property (ok && ctrl_q[18:16] == 3'h7 |-> pulse_out_pin == $past(encoder_pulse, 3))
        else $error("encoder pass");
    a_no_src: assert property (ok && ctrl_q[18:16] == 3'h0 |=> $stable(pulse_out_pin))
        else $error("pulse without source");
    c_refused: cover property (pslverr_q);
    c_set_err: cover property ($rose(pulse_setting_error));
    c_ref_on: cover property (pulse_ref_active_q && pulse_freq_ref_q != 24'h000000);
endmodule // ptio_top_checker
bind ptio_top ptio_top_checker i_ptio_top_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .encoder_pulse(encoder_pulse), .opto_func(opto_func), .pulse_out_pin(pulse_out_pin),
    .optocoupler_output(optocoupler_output), .pulse_setting_error(pulse_setting_error),
    .pulse_ref_active_q(pulse_ref_active_q), .pulse_freq_ref_q(pulse_freq_ref_q)
);
`default_nettype wire

// >>> dv/test_pulse_train_input_output.sv
/* Self-checking bench of ptio_top with the pulse partner model.
   Assumes design, partner and checker are compiled before it. */
`default_nettype none
`include "ptio_defs.vh"
module test_pulse_train_input_output;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [`PTIO_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata_q, r;
    logic pready_q, pslverr_q, e, pulse_in_pin, pulse_out_pin, opto_out, set_err, ref_act, xe, xr;
    logic encoder_pulse = 1'b0, opto_func = 1'b0;
    logic [15:0] pct [1:6], lfsr = 16'h0026, cent = 16'h0000;
    logic [23:0] ref_q;
    logic [11:0] ra [6] = '{`PTIO_ADDR_CTRL, `PTIO_ADDR_IN_SCALE, `PTIO_ADDR_GAIN, `PTIO_ADDR_BIAS,
        `PTIO_ADDR_FILT, `PTIO_ADDR_OUT_SCALE};
    logic [31:0] rv [6] = '{32'h00020000, 32'h00002710, 32'h000003E8, 32'h0, 32'h0, 32'h00002710};
    int miscompares = 0, tests_run = 0, mon, gain, bias, c0;
    ptio_top #(.FILT_STEP_CYC(24'h000004)) i_ptio_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .pulse_in_pin(pulse_in_pin), .encoder_pulse(encoder_pulse), .freq_cmd_pct(pct[1]),
        .out_freq_pct(pct[2]), .soft_start_stage_pct(pct[3]), .motor_speed_pct(pct[4]),
        .pid_fb_pct(pct[5]), .pid_in_pct(pct[6]), .out_freq_centihz(cent), .opto_func(opto_func),
        .pulse_out_pin(pulse_out_pin), .optocoupler_output(opto_out), .pulse_setting_error(set_err),
        .pulse_ref_active_q(ref_act), .pulse_freq_ref_q(ref_q)
    );
    ptio_pulse_ext i_ext (.pclk(pclk), .pulse_out_pin(pulse_out_pin), .pulse_in_pin(pulse_in_pin));
    initial forever #50 pclk = ~pclk;
    function automatic logic [15:0] lfsr_f(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    always @(posedge pclk) begin
        lfsr <= lfsr_f(lfsr);
        encoder_pulse <= lfsr[0];
        opto_func <= lfsr[5];
    end
    // ------
    // Tasks
    // ------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic near(input logic [31:0] got, input int exp, input int tol);
        tests_run++;
        if ($isunknown(got) || $signed(got) > exp + tol || $signed(got) < exp - tol) begin
            miscompares++;
            $display("Error at %0t: got %0d expected %0d", $time, $signed(got), exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready_q !== 1'b1);
        r = prdata_q;
        e = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [31:0] ctrl(input int md, input int pfb, input int pen, input int rs, input int os,
        input int pol);
        return 32'(md | rs << 4 | pfb << 8 | pen << 12 | os << 16 | pol << 20);
    endfunction
    task automatic settle(input int p, input int h);
        int w;
        w = i_ext.period_cyc + p + 800;
        i_ext.period_cyc = p;
        i_ext.high_cyc = h;
        repeat (w) @(posedge pclk);
    endtask
    task automatic rises(input int w, input int x);
        c0 = i_ext.rise_cnt;
        repeat (w) @(posedge pclk);
        near(32'(i_ext.rise_cnt - c0), x, 1);
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (98000) @(posedge pclk);
        miscompares++;
        wrap_up();
    end
    // ------
    // Sequence
    // ------
    initial begin
        for (int k = 1; k <= 6; k++) pct[k] = 16'(k * 5000);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0);
            chk(r, rv[i]);
        end
        apb(1'b1, 12'h030, 32'h0000FFFF);
        chk(e, 1'b1);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, `PTIO_ADDR_CTRL, ctrl(i & 1, i[1] ? 3 : 2, i[2], i[3] ? 4 : 1, 2, 0));
            repeat (4) @(posedge pclk);
            xe = i[0] ? !i[1] : i[2];
            xr = i[3] && !i[0];
            chk(set_err, xe);
            chk(ref_act, xr);
            apb(1'b0, `PTIO_ADDR_STATUS, 32'h0);
            chk(r & 32'h6, {xr, xe, 1'b0});
        end
        apb(1'b1, `PTIO_ADDR_CTRL, ctrl(0, 2, 0, 4, 2, 0));
        repeat (2) begin
            gain = 1000 + int'(lfsr % 9001);
            bias = int'(lfsr % 2001) - 1000;
            apb(1'b1, `PTIO_ADDR_GAIN, 32'(gain));
            apb(1'b1, `PTIO_ADDR_BIAS, 32'(bias));
            settle(800 + int'(lfsr % 400), 400);
            mon = 10000000 / i_ext.period_cyc;
            apb(1'b0, `PTIO_ADDR_MON, 32'h0);
            near(r, mon, 2);
            mon = mon * gain / 1000 + bias * 10;
            apb(1'b0, `PTIO_ADDR_TARGET, 32'h0);
            near(r, mon, 30);
            near(32'($signed(ref_q)), mon, 30);
        end
        apb(1'b1, `PTIO_ADDR_CTRL, ctrl(1, 3, 0, 4, 2, 0));
        apb(1'b1, `PTIO_ADDR_IN_SCALE, 32'h000003E8);
        apb(1'b1, `PTIO_ADDR_FILT, 32'h1);
        for (int i = 0; i < 2; i++) begin
            settle(i ? 11300 : 10000, 2500 + int'(lfsr % 5000));
            mon = i ? 0 : i_ext.high_cyc;
            apb(1'b0, `PTIO_ADDR_MON, 32'h0);
            near(r, mon, 2);
            apb(1'b0, `PTIO_ADDR_STATUS, 32'h0);
            chk(r & 32'h1, i == 0);
        end
        apb(1'b1, `PTIO_ADDR_OUT_SCALE, 32'h00007D00);
        for (int k = 0; k <= 6; k++) begin
            apb(1'b1, `PTIO_ADDR_CTRL, ctrl(0, 2, 0, 1, k, 0));
            rises(2500, k * 5000 * 32000 / 10000 * 2500 / 10000000);
        end
        cent <= 16'hFDE8;
        apb(1'b1, `PTIO_ADDR_OUT_SCALE, 32'h0);
        apb(1'b1, `PTIO_ADDR_CTRL, ctrl(0, 2, 0, 1, 2, 0));
        repeat (31500) @(posedge pclk);
        near(32'(i_ext.gap), 1000000000 / 65000, 2);
        apb(1'b1, `PTIO_ADDR_CTRL, ctrl(0, 2, 0, 1, 7, 1));
        repeat (300) @(posedge pclk);
        xe = opto_func;
        @(posedge pclk);
        chk(opto_out, !xe);
        wrap_up();
    end
endmodule // test_pulse_train_input_output
`default_nettype wire
